// file: lcd_port_params.svh
`ifndef LCD_PORT_PARAMS_SVH
`define LCD_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define LCDP_DATA_W 8
// Pin bundle idle: straps 0, reset pin 1, select 1, read 1, write 1, A-line 0, data 0
`define LCDP_PIN_IDLE 15'h1e00
`define LCDP_BUS_IDLE 8'h00

`endif

// file: lcd_port_pkg.sv
`default_nettype none
`include "lcd_port_params.svh"

package lcd_port_pkg;

    // ----------------------------------------------------------------
    // Host interface style
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STROBE,
        MODE_ENABLE,
        MODE_NONE
    } host_mode_e;

    // Pin bundle as seen at the package
    typedef struct packed {
        logic host_family_select_a;
        logic host_family_select_b;
        logic hw_reset_n;
        logic cs_n;
        logic rd_e;
        logic wr_rw;
        logic cmd_data_select;
        logic [`LCDP_DATA_W-1:0] data;
    } pin_s;

    // Byte handed to the controller core
    typedef struct packed {
        logic valid;
        logic is_cmd;
        logic [`LCDP_DATA_W-1:0] data;
    } host_write_s;

    // Whole state of the port
    typedef struct packed {
        pin_s s1;
        pin_s s2;
        pin_s s3;
        pin_s filt;
        logic [`LCDP_DATA_W-1:0] bus_out;
        logic bus_oe;
        host_write_s wr;
        logic rd_pulse;
        logic ctrl_reset;
    } port_state_s;

endpackage : lcd_port_pkg

`default_nettype wire

// file: lcd_ctrl_host_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_port_params.svh"

module lcd_ctrl_host_bus_port
    import lcd_port_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_host_family_select_a,
    input wire logic i_host_family_select_b,
    input wire logic i_hw_reset_n,
    input wire logic i_cs_n,
    input wire logic i_rd_e,
    input wire logic i_wr_rw,
    input wire logic i_cmd_data_select,
    input wire logic [`LCDP_DATA_W-1:0] i_host_data_bus,
    input wire logic [`LCDP_DATA_W-1:0] i_status_byte,
    input wire logic [`LCDP_DATA_W-1:0] i_read_data,
    output logic [`LCDP_DATA_W-1:0] o_host_data_bus,
    output logic o_host_data_bus_oe,
    output host_write_s o_host_write,
    output logic o_data_read_pulse,
    output logic o_ctrl_reset
);

    // ----------------------------------------------------------------
    // State and reset value
    // ----------------------------------------------------------------
    localparam port_state_s ST_RESET = '{
        s1: `LCDP_PIN_IDLE,
        s2: `LCDP_PIN_IDLE,
        s3: `LCDP_PIN_IDLE,
        filt: `LCDP_PIN_IDLE,
        bus_out: `LCDP_BUS_IDLE,
        bus_oe: 1'b0,
        wr: '0,
        rd_pulse: 1'b0,
        ctrl_reset: 1'b0
    };

    port_state_s st_reg;
    port_state_s st_next;
    pin_s pins_in;
    host_mode_e mode;
    logic selected;
    logic read_active;
    logic write_edge;
    logic read_start;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // A bit follows the pin once the second and third stages agree
    function automatic pin_s settle(input pin_s s2, input pin_s s3, input pin_s held);
        pin_s diff;
        diff = s2 ^ s3;
        return (~diff & s3) | (diff & held);
    endfunction : settle

    // Interface style from the two straps
    function automatic host_mode_e mode_of(input pin_s p);
        host_mode_e m;
        m = MODE_NONE;
        if (!p.host_family_select_a && !p.host_family_select_b) begin
            m = MODE_STROBE;
        end else if (p.host_family_select_a && !p.host_family_select_b) begin
            m = MODE_ENABLE;
        end
        return m;
    endfunction : mode_of

    // Pins gathered into one bundle
    assign pins_in = {i_host_family_select_a, i_host_family_select_b, i_hw_reset_n, i_cs_n,
                      i_rd_e, i_wr_rw, i_cmd_data_select, i_host_data_bus};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        mode = mode_of(st_reg.filt);
        selected = !st_reg.filt.cs_n;
        read_active = 1'b0;
        write_edge = 1'b0;
        read_start = 1'b0;

        // Three-stage synchroniser, first stage read only by the second
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.filt = settle(st_reg.s2, st_reg.s3, st_reg.filt);

        // Strobe decode per style
        unique case (mode)
            MODE_STROBE: begin
                read_active = selected && !st_reg.filt.rd_e;
                write_edge = selected && !st_reg.filt.wr_rw
                             && st_next.filt.wr_rw;
                read_start = selected && st_reg.filt.rd_e && !st_next.filt.rd_e;
            end
            MODE_ENABLE: begin
                read_active = selected && st_reg.filt.rd_e && st_reg.filt.wr_rw;
                write_edge = selected && !st_reg.filt.rd_e && st_next.filt.rd_e
                             && !st_next.filt.wr_rw;
                read_start = selected && !st_reg.filt.rd_e && st_next.filt.rd_e
                             && st_next.filt.wr_rw;
            end
            MODE_NONE: begin
                read_active = 1'b0;
            end
        endcase

        // Read path: status on select 0, data or cursor on select 1
        st_next.bus_oe = read_active;
        if (!read_active) begin
            st_next.bus_out = `LCDP_BUS_IDLE;
        end else if (st_reg.filt.cmd_data_select) begin
            st_next.bus_out = i_read_data;
        end else begin
            st_next.bus_out = i_status_byte;
        end
        st_next.rd_pulse = read_start && st_reg.filt.cmd_data_select;

        // Write path: select 1 marks a command code
        st_next.wr.valid = write_edge;
        // Kind and byte hold until the next write edge, even one blocked by the reset pin
        if (write_edge) begin
            st_next.wr.is_cmd = st_reg.filt.cmd_data_select;
            st_next.wr.data = (mode == MODE_STROBE) ? st_reg.filt.data : st_next.filt.data;
        end

        // Reset pin low: hold the core in reset and keep the port quiet
        st_next.ctrl_reset = !st_reg.filt.hw_reset_n;
        if (!st_reg.filt.hw_reset_n) begin
            st_next.bus_oe = 1'b0;
            st_next.bus_out = `LCDP_BUS_IDLE;
            st_next.wr.valid = 1'b0;
            st_next.rd_pulse = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign o_host_data_bus = st_reg.bus_out;
    assign o_host_data_bus_oe = st_reg.bus_oe;
    assign o_host_write = st_reg.wr;
    assign o_data_read_pulse = st_reg.rd_pulse;
    assign o_ctrl_reset = st_reg.ctrl_reset;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_write_mode_valid: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_write.valid |-> !$past(st_reg.filt.host_family_select_b))
        else $error("Write taken with an unsupported strap setting");

    a_strobe_read_oe: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_data_bus_oe && !$past(st_reg.filt.host_family_select_a)
        |-> !$past(st_reg.filt.rd_e))
        else $error("Bus driven without read strobe low");

    a_strobe_write_edge: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_write.valid && !$past(st_reg.filt.host_family_select_a)
        |-> !$past(st_reg.filt.wr_rw) && st_reg.filt.wr_rw
            && o_host_write.data == $past(st_reg.filt.data))
        else $error("Strobe write not taken at write rising edge");

    a_enable_write_edge: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_write.valid && $past(st_reg.filt.host_family_select_a)
        |-> !$past(st_reg.filt.rd_e) && st_reg.filt.rd_e && !st_reg.filt.wr_rw)
        else $error("Enable write not taken at enable rising edge");

    a_status_read: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_data_bus_oe && !$past(st_reg.filt.cmd_data_select)
        |-> o_host_data_bus == $past(i_status_byte))
        else $error("Status read returned wrong byte");

    a_data_read: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_data_bus_oe && $past(st_reg.filt.cmd_data_select)
        |-> o_host_data_bus == $past(i_read_data))
        else $error("Data read returned wrong byte");

    a_write_kind: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_host_write.valid |-> o_host_write.is_cmd == $past(st_reg.filt.cmd_data_select))
        else $error("Write kind does not follow select line");

    a_bus_release: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        !o_host_data_bus_oe |-> o_host_data_bus == `LCDP_BUS_IDLE)
        else $error("Bus value present while released");

    // No read strobe in either style: strap a differs from the read or enable pin
    a_no_read_release: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        $past(st_reg.filt.host_family_select_a) != $past(st_reg.filt.rd_e)
        |-> !o_host_data_bus_oe && o_host_data_bus == `LCDP_BUS_IDLE)
        else $error("Bus not released without a read");

    a_chip_select: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (o_host_data_bus_oe || o_host_write.valid) |-> !$past(st_reg.filt.cs_n))
        else $error("Access acted on without chip select");

    a_hw_reset: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        !$past(st_reg.filt.hw_reset_n)
        |-> o_ctrl_reset && !o_host_data_bus_oe && !o_host_write.valid)
        else $error("Reset pin low did not reset the controller");

endmodule : lcd_ctrl_host_bus_port

`default_nettype wire

// file: host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Host processor bus master
// ------------------------------------------------
module host_bus_model (
    input wire logic i_clk,
    output logic o_sel_a,
    output logic o_sel_b,
    output logic o_hw_reset_n,
    output logic o_cs_n,
    output logic o_rd_e,
    output logic o_wr_rw,
    output logic o_a,
    output logic [7:0] o_data
);
    // Idle pins at time zero
    initial begin
        {o_sel_a, o_sel_b, o_hw_reset_n, o_cs_n, o_rd_e, o_wr_rw, o_a} = 7'b0011110;
        o_data = 8'h00;
    end
    // One access: set up, strobe for ten cycles, recover, release
    task automatic access(input logic enb, input logic rd, input logic a,
                          input logic [7:0] d, input logic cs);
        @(negedge i_clk);
        o_sel_a = enb;
        o_cs_n = ~cs;
        o_a = a;
        o_data = rd ? ~o_data : d; // Old byte inverted on reads
        o_wr_rw = enb ? rd : 1'b1;
        o_rd_e = ~enb;
        repeat (3) @(negedge i_clk);
        if (enb) o_rd_e = 1'b1;
        else if (rd) o_rd_e = 1'b0;
        else o_wr_rw = 1'b0;
        repeat (10) @(negedge i_clk);
        o_rd_e = ~enb;
        if (!enb) o_wr_rw = 1'b1;
        repeat (3) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_data = ~o_data; // Released line shows no stale byte
    endtask : access
endmodule : host_bus_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Port testbench
// ------------------------------------------------
module tb_top
    import lcd_port_pkg::*;
;
    typedef struct packed {
        logic enb;
        logic rd;
        logic a;
        logic [7:0] d;
        logic [7:0] exp;
        logic flag;
    } row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] status_b = 8'h00;
    logic [7:0] read_b = 8'h00;
    logic sel_a, sel_b, hw_n, cs_n, rd_e, wr_rw, a_l, oe, rdp, creset, w_cmd, mid_oe;
    logic [7:0] h_data, bus_wire, d_out, w_data, mid_bus;
    host_write_s hw;
    int n_errors = 0;
    int n_tests = 0;
    int n_valid = 0;
    int n_rdp = 0;
    // Mode, direction, A-line, byte, expected byte, kind or pulse
    row_s rows [8] = '{
        '{1'b0, 1'b0, 1'b0, 8'h3c, 8'h3c, 1'b0},
        '{1'b0, 1'b0, 1'b1, 8'h81, 8'h81, 1'b1},
        '{1'b0, 1'b1, 1'b0, 8'h12, 8'h12, 1'b0},
        '{1'b0, 1'b1, 1'b1, 8'h34, 8'hcb, 1'b1},
        '{1'b1, 1'b0, 1'b0, 8'hff, 8'hff, 1'b0},
        '{1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 1'b1},
        '{1'b1, 1'b1, 1'b0, 8'h56, 8'h56, 1'b0},
        '{1'b1, 1'b1, 1'b1, 8'h78, 8'h87, 1'b1}};
    always #20 clk = ~clk;
    // Shared data wire
    assign bus_wire = oe ? d_out : h_data;
    host_bus_model host_u (.i_clk(clk), .o_sel_a(sel_a), .o_sel_b(sel_b), .o_hw_reset_n(hw_n),
        .o_cs_n(cs_n), .o_rd_e(rd_e), .o_wr_rw(wr_rw), .o_a(a_l), .o_data(h_data));
    lcd_ctrl_host_bus_port dut_u (.i_core_clk(clk), .i_resetn(resetn),
        .i_host_family_select_a(sel_a), .i_host_family_select_b(sel_b), .i_hw_reset_n(hw_n),
        .i_cs_n(cs_n), .i_rd_e(rd_e), .i_wr_rw(wr_rw), .i_cmd_data_select(a_l),
        .i_host_data_bus(bus_wire), .i_status_byte(status_b), .i_read_data(read_b),
        .o_host_data_bus(d_out), .o_host_data_bus_oe(oe), .o_host_write(hw),
        .o_data_read_pulse(rdp), .o_ctrl_reset(creset));
    // Count pulses handed to the core, sampled away from the launching edge
    always @(negedge clk) begin
        if (hw.valid === 1'b1) begin
            n_valid++;
            w_cmd = hw.is_cmd;
            w_data = hw.data;
        end
        if (rdp === 1'b1) n_rdp++;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One access with the bus sampled mid-strobe
    task automatic run(input row_s r, input logic cs);
        @(negedge clk);
        n_valid = 0;
        n_rdp = 0;
        status_b = r.d;
        read_b = ~r.d;
        fork
            host_u.access(r.enb, r.rd, r.a, r.d, cs);
            begin
                repeat (12) @(negedge clk);
                mid_oe = oe;
                mid_bus = d_out;
            end
        join
        repeat (8) @(negedge clk);
    endtask : run
    task final_report;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // Watchdog
    initial begin
        #(40 * 3000);
        n_errors++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        chk("oe in reset", 8'h00, {7'h0, oe});
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        foreach (rows[i]) begin
            run(rows[i], 1'b1);
            if (rows[i].rd) begin
                chk("read byte", rows[i].exp, mid_bus);
                chk("read oe", 8'h01, {7'h0, mid_oe});
                chk("read pulse", {7'h0, rows[i].flag}, n_rdp[7:0]);
            end else begin
                chk("write count", 8'h01, n_valid[7:0]);
                chk("write data", rows[i].exp, w_data);
                chk("write kind", {7'h0, rows[i].flag}, {7'h0, w_cmd});
            end
            chk("released oe", 8'h00, {7'h0, oe});
            chk("released bus", 8'h00, d_out);
        end
        // Chip select high: nothing taken, bus stays released
        run(rows[0], 1'b0);
        chk("cs write", 8'h00, n_valid[7:0]);
        run(rows[3], 1'b0);
        chk("cs read", 8'h00, {7'h0, mid_oe});
        // Reserved strap pair
        host_u.o_sel_b = 1'b1;
        run(rows[4], 1'b1);
        chk("strap write", 8'h00, n_valid[7:0]);
        run(rows[3], 1'b1);
        chk("strap read", 8'h00, {7'h0, mid_oe});
        host_u.o_sel_b = 1'b0;
        // Reset pin held low blocks a write
        host_u.o_hw_reset_n = 1'b0;
        repeat (8) @(negedge clk);
        run(rows[1], 1'b1);
        chk("hw reset", 8'h01, {7'h0, creset});
        chk("hw reset write", 8'h00, n_valid[7:0]);
        host_u.o_hw_reset_n = 1'b1;
        repeat (8) @(negedge clk);
        chk("hw reset end", 8'h00, {7'h0, creset});
        final_report();
    end
endmodule : tb_top
`default_nettype wire
